// >>> hw/fuse_rd_pkg.sv
// Constants for the fuse and lock byte readback block.
// Assumes a single CPU clock domain at 25 MHz.
package fuse_rd_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 8;
  localparam logic [15:0] SEL_FUSE_LOW    = 16'h0000;
  localparam logic [15:0] SEL_LOCK        = 16'h0001;
  localparam int          CTRL_LOCKSEL    = 3;
  localparam int          CTRL_SPEN       = 0;
  localparam int          WIN_CYCLES      = 3;
  localparam logic [1:0]  WIN_CNT_W       = 2'h3;
  localparam logic [7:0]  FUSE_LOW_RST    = 8'hFF;
  localparam logic [7:0]  LOCK_RST        = 8'hFF;
  localparam logic [7:0]  UNMAPPED_DATA   = 8'hFF;
endpackage

// >>> hw/arm_window.sv
// Three-cycle arming window for the configuration readback.
// Assumes set/consume pulses synchronous to clock_i.
`timescale 1ns/1ps
module arm_window
  import fuse_rd_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  input  wire logic arm_i,
  input  wire logic done_i,
  output logic      armed_o
);
  logic [1:0] left_reg;
  logic [1:0] left_next;

  // Reload on arm; done or count-out ends the window
  assign left_next = arm_i ? WIN_CNT_W :
                     (done_i || left_reg == 2'h0) ? 2'h0 :
                     left_reg - 2'h1;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      left_reg <= 2'h0;
    else if (ce_i)
      left_reg <= left_next;
  end

  assign armed_o = (left_reg != 2'h0);
endmodule

// >>> hw/fuse_lock_bit_readback.sv
// Software readback of the lock byte and the low fuse byte.
// Assumes the core pulses load/store strobes with the pointer value;
// fuse and lock bytes arrive as stable levels, zero meaning programmed.
`timescale 1ns/1ps
// How it works
// - Load of the lock selector within three cycles returns lock byte
// - Control bits self-clear on read or timeout
// - Load of the fuse selector within three cycles returns fuse byte
// - Fuse bit n lands at result bit n
// - Programmed reads zero, unprogrammed reads one
// - No readback while EEPROM write runs
module fuse_lock_bit_readback
  import fuse_rd_pkg::*;
(
  input  wire logic                        clock_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        ce_i,
  input  wire logic                        ctrl_wr_i,
  input  wire logic [fuse_rd_pkg::DATA_W-1:0] ctrl_wdata_i,
  input  wire logic                        pm_load_i,
  input  wire logic                        pm_store_i,
  input  wire logic [fuse_rd_pkg::ADDR_W-1:0] ptr_i,
  input  wire logic [fuse_rd_pkg::DATA_W-1:0] fuse_low_bits_i,
  input  wire logic [fuse_rd_pkg::DATA_W-1:0] lock_bits_i,
  input  wire logic                        ee_busy_i,
  output logic                             lockbit_select_o,
  output logic                             self_prog_enable_o,
  output logic                             cfg_hit_o,
  output logic [fuse_rd_pkg::DATA_W-1:0]   rd_data_o
);
  import fuse_rd_pkg::*;

  logic                armed;
  logic                arm_set;
  logic                hit;
  logic                window_end;
  logic [DATA_W-1:0]   sel_byte;
  logic                lsel_reg;
  logic                spen_reg;
  logic                hit_reg;
  logic [DATA_W-1:0]   data_reg;

  // Writing both bits arms; EEPROM write blocks arming entirely
  assign arm_set = ctrl_wr_i && ctrl_wdata_i[CTRL_LOCKSEL]
                   && ctrl_wdata_i[CTRL_SPEN] && !ee_busy_i;
  // Load while armed is the read; store consumes the window too
  assign hit        = armed && pm_load_i && !ee_busy_i;
  assign window_end = armed && (pm_load_i || pm_store_i);

  // Raw bits pass untouched: zero already means programmed
  assign sel_byte = (ptr_i == SEL_LOCK)     ? lock_bits_i :
                    (ptr_i == SEL_FUSE_LOW) ? fuse_low_bits_i :
                    UNMAPPED_DATA;

  arm_window u_win (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .arm_i     (arm_set),
    .done_i    (window_end),
    .armed_o   (armed)
  );

  // Control bits follow the window: clear on read or store, and one cycle after count-out
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lsel_reg <= 1'b0;
      spen_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (arm_set)
      begin
        lsel_reg <= 1'b1;
        spen_reg <= 1'b1;
      end
      else if (window_end || (armed == 1'b0))
      begin
        lsel_reg <= 1'b0;
        spen_reg <= 1'b0;
      end
    end
  end

  // Result byte registered for the core's destination write
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hit_reg  <= 1'b0;
      data_reg <= 8'h00;
    end
    else if (ce_i)
    begin
      hit_reg <= hit;
      if (hit)
        data_reg <= sel_byte;
    end
  end

  assign lockbit_select_o   = lsel_reg;
  assign self_prog_enable_o = spen_reg;
  assign cfg_hit_o          = hit_reg;
  assign rd_data_o          = data_reg;

  // One clock domain; reset disables every attempt
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  // Armed load on the lock selector
  sequence s_lock_read;
    ce_i && hit && ptr_i == SEL_LOCK;
  endsequence

  sequence s_fuse_read;
    ce_i && hit && ptr_i == SEL_FUSE_LOW;
  endsequence

  // Arm, then three run cycles with neither load nor store
  sequence s_armed_idle;
    ce_i && arm_set
    ##1 (ce_i && !pm_load_i && !pm_store_i && !arm_set) [*3];
  endsequence

  // Lock selector load inside the window returns the lock byte
  a_lock_return: assert property (
    s_lock_read
    |=> cfg_hit_o && rd_data_o == $past(lock_bits_i))
    else $error("lock byte not returned");

  // Fuse selector returns the fuse byte
  a_fuse_return: assert property (
    s_fuse_read
    |=> cfg_hit_o && rd_data_o == $past(fuse_low_bits_i))
    else $error("fuse byte not returned");

  // Bits clear on the edge after the window runs out
  a_timeout_clear: assert property (
    s_armed_idle ##1 (ce_i && !arm_set)
    |=> !lockbit_select_o && !self_prog_enable_o)
    else $error("control bits stuck after timeout");

  // A load after the third cycle is too late
  a_late_load: assert property (
    s_armed_idle ##1 (ce_i && pm_load_i && !arm_set)
    |=> !cfg_hit_o)
    else $error("late load answered");

  // Completed read clears the self-programming enable bit and closes the window
  a_read_clear: assert property (
    (ce_i && hit && !arm_set)
    |=> !self_prog_enable_o && !armed)
    else $error("control bits not cleared after read");

  // Store inside the window ends it without data
  a_store_clear: assert property (
    (ce_i && armed && pm_store_i && !arm_set)
    |=> !lockbit_select_o && !armed)
    else $error("store left window open");

  // EEPROM busy blocks any result
  a_ee_block: assert property (
    (ce_i && ee_busy_i)
    |=> !cfg_hit_o)
    else $error("readback during EEPROM write");

  // EEPROM busy keeps an idle block from arming
  a_arm_blocked: assert property (
    (ce_i && ctrl_wr_i && ee_busy_i && !lockbit_select_o && !armed)
    |=> !lockbit_select_o)
    else $error("armed during EEPROM write");

  // Load without arming yields no result
  a_no_arm: assert property (
    (ce_i && pm_load_i && !armed)
    |=> !cfg_hit_o)
    else $error("readback without arming");

  // Arming shows both bits on the next edge
  a_arm_show: assert property (
    (ce_i && arm_set)
    |=> lockbit_select_o && self_prog_enable_o && armed)
    else $error("arming not visible");

  // Raw polarity kept: all-programmed reads zero
  a_polarity: assert property (
    (ce_i && hit && ptr_i == SEL_LOCK && lock_bits_i == 8'h00)
    |=> rd_data_o == 8'h00)
    else $error("polarity inverted");

  // End bits of the fuse byte keep their places
  a_fuse_map: assert property (
    s_fuse_read
    |=> rd_data_o[7] == $past(fuse_low_bits_i[7])
        && rd_data_o[0] == $past(fuse_low_bits_i[0]))
    else $error("fuse bits moved");

  // Result holds until the next read
  a_data_hold: assert property (
    !(ce_i && hit)
    |=> $stable(rd_data_o))
    else $error("result changed without read");

  // Unknown selector reads all ones
  a_unmapped_ff: assert property (
    (ce_i && hit && ptr_i != SEL_LOCK && ptr_i != SEL_FUSE_LOW)
    |=> rd_data_o == UNMAPPED_DATA)
    else $error("unmapped selector data");

  // Low enable freezes the lock select and hit outputs
  a_freeze_hold: assert property (
    !ce_i
    |=> $stable(lockbit_select_o) && $stable(cfg_hit_o))
    else $error("state moved while frozen");

  // Both control bits always move together
  a_ctrl_pair: assert property (
    lockbit_select_o == self_prog_enable_o)
    else $error("control bits disagree");
endmodule

// >>> dv/core_model.sv
// Core model: control writes and load strobes, one per cycle.
// Assumes the bench calls op from one process only.
`timescale 1ns/1ps
module core_model
(
  input  wire logic  clock_i,
  output logic       ctrl_wr_o,
  output logic [7:0] ctrl_wdata_o,
  output logic       pm_load_o,
  output logic [15:0] ptr_o
);
  // Idle at time zero
  initial
  begin
    ctrl_wr_o    = 1'b0;
    ctrl_wdata_o = 8'h00;
    pm_load_o    = 1'b0;
    ptr_o        = 16'h0000;
  end
  // Unused buses toggle so stale values never pass for real ones
  task automatic op(input logic w, input logic ld, input logic [15:0] p);
    @(posedge clock_i);
    #1;
    ctrl_wr_o    = w;
    ctrl_wdata_o = w ? 8'h09 : ~ctrl_wdata_o;
    pm_load_o    = ld;
    ptr_o        = ld ? p : ~ptr_o;
  endtask
endmodule

// >>> dv/fuse_lock_bit_readback_bench.sv
// Bench for the configuration byte readback.
// Assumes core_model drives the control write, load and pointer inputs; the bench drives the store strobe.
`timescale 1ns/1ps
module fuse_lock_bit_readback_bench;
  import fuse_rd_pkg::*;
  localparam logic [7:0] FUSE = 8'hA5;
  localparam logic [7:0] LOCK = 8'h3C;
  logic        clock_i, sys_rst_i, ee_busy_i, cw, ld, lsel, spen, hit;
  logic [7:0]  wd, rd;
  logic [15:0] ptr;
  logic        ce, st;
  logic [7:0]  lock_v;
  int          num_errors, total_checks;
  // 25 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  core_model core (.clock_i(clock_i), .ctrl_wr_o(cw), .ctrl_wdata_o(wd),
    .pm_load_o(ld), .ptr_o(ptr));
  // Store strobe, clock enable and lock byte driven by the bench
  fuse_lock_bit_readback dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce), .ctrl_wr_i(cw), .ctrl_wdata_i(wd), .pm_load_i(ld),
    .pm_store_i(st), .ptr_i(ptr), .fuse_low_bits_i(FUSE),
    .lock_bits_i(lock_v), .ee_busy_i(ee_busy_i), .lockbit_select_o(lsel),
    .self_prog_enable_o(spen), .cfg_hit_o(hit), .rd_data_o(rd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Arm, load d cycles later, expect byte e
  task automatic t_read(input int d, input logic [15:0] p,
                        input logic [7:0] e);
    core.op(1'b1, 1'b0, 16'h0000);
    for (int i = 1; i < d; i++)
      core.op(1'b0, 1'b0, 16'h0000);
    core.op(1'b0, 1'b1, p);
    chk({6'h00, lsel, spen}, 8'h03);
    core.op(1'b0, 1'b0, 16'h0000);
    chk({7'h00, hit}, 8'h01);
    chk(rd, e);
    chk({6'h00, lsel, spen}, 8'h00);
    core.op(1'b0, 1'b0, 16'h0000);
    chk({7'h00, hit}, 8'h00);
  endtask
  // Load that must be refused: late or EEPROM busy
  task automatic t_miss(input logic busy, input int d);
    ee_busy_i = busy;
    core.op(1'b1, 1'b0, 16'h0000);
    for (int i = 1; i < d; i++)
      core.op(1'b0, 1'b0, 16'h0000);
    core.op(1'b0, 1'b1, SEL_LOCK);
    core.op(1'b0, 1'b0, 16'h0000);
    chk({5'h00, hit, lsel, spen}, 8'h00);
    ee_busy_i = 1'b0;
  endtask
  // Store inside the window ends it; a later load gets nothing
  task automatic t_store;
    core.op(1'b1, 1'b0, 16'h0000);
    core.op(1'b0, 1'b0, 16'h0000);
    st = 1'b1;
    core.op(1'b0, 1'b0, 16'h0000);
    st = 1'b0;
    chk({6'h00, lsel, spen}, 8'h00);
    core.op(1'b0, 1'b1, SEL_LOCK);
    core.op(1'b0, 1'b0, 16'h0000);
    chk({7'h00, hit}, 8'h00);
  endtask
  // Clock enable low freezes the window mid-way
  task automatic t_freeze;
    core.op(1'b1, 1'b0, 16'h0000);
    core.op(1'b0, 1'b0, 16'h0000);
    ce = 1'b0;
    repeat (5) core.op(1'b0, 1'b0, 16'h0000);
    chk({6'h00, lsel, spen}, 8'h03);
    ce = 1'b1;
    core.op(1'b0, 1'b1, SEL_LOCK);
    core.op(1'b0, 1'b0, 16'h0000);
    chk({7'h00, hit}, 8'h01);
    chk(rd, LOCK);
  endtask
  // EEPROM write starts after arming: the load is refused
  task automatic t_busy_load;
    core.op(1'b1, 1'b0, 16'h0000);
    core.op(1'b0, 1'b0, 16'h0000);
    ee_busy_i = 1'b1;
    core.op(1'b0, 1'b1, SEL_LOCK);
    core.op(1'b0, 1'b0, 16'h0000);
    chk({7'h00, hit}, 8'h00);
    ee_busy_i = 1'b0;
  endtask
  // Reset in mid-window drops the window and the result
  task automatic t_reset_mid;
    core.op(1'b1, 1'b0, 16'h0000);
    core.op(1'b0, 1'b0, 16'h0000);
    sys_rst_i = 1'b1;
    core.op(1'b0, 1'b0, 16'h0000);
    chk({5'h00, hit, lsel, spen}, 8'h00);
    chk(rd, 8'h00);
    sys_rst_i = 1'b0;
    core.op(1'b0, 1'b1, SEL_LOCK);
    core.op(1'b0, 1'b0, 16'h0000);
    chk({7'h00, hit}, 8'h00);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    sys_rst_i    = 1'b1;
    ee_busy_i    = 1'b0;
    ce           = 1'b1;
    st           = 1'b0;
    lock_v       = LOCK;
    num_errors   = 0;
    total_checks = 0;
    repeat (8) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    chk({5'h00, hit, lsel, spen}, 8'h00);
    t_read(1, SEL_LOCK, LOCK);
    t_read(3, SEL_FUSE_LOW, FUSE);
    t_read(2, 16'h0005, UNMAPPED_DATA);
    t_miss(1'b0, 4);
    t_miss(1'b1, 1);
    t_store;
    t_freeze;
    t_busy_load;
    t_reset_mid;
    lock_v = 8'h00;
    t_read(2, SEL_LOCK, 8'h00);
    lock_v = LOCK;
    end_of_test;
  end
endmodule
